// file: core/scn_sequencer.sv
// Terminal-side supply class negotiation: activation, answer wait, class retry
// and current budget tracking. Assumes an outside character receiver on the
// card data line and a supply switch that follows the class select pins.
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module scn_sequencer #(
   parameter int unsigned CARD_HALF = scn_pkg::CARD_HALF_CYC,
   parameter int unsigned RST_LOW   = scn_pkg::RST_LOW_CLKS,
   parameter int unsigned CORR_MAX  = scn_pkg::CORRUPT_LIMIT
) (
   input  wire logic                ref_clk_in,
   input  wire logic                nrst_in,
   input  wire logic [4:0]          avs_address_in,
   input  wire logic                avs_read_in,
   input  wire logic                avs_write_in,
   input  wire logic [31:0]         avs_writedata_in,
   output logic      [31:0]         avs_readdata_out,
   output logic                     avs_waitrequest_out,
   input  wire scn_pkg::scn_char_t  atr_char_in,
   output scn_pkg::scn_card_t       card_out,
   output logic                     card_ready_out,
   output logic                     reject_out,
   output logic      [15:0]         budget_out
);
   import scn_pkg::*;

   localparam logic [7:0]  HALF_M1  = 8'(CARD_HALF - 1);
   localparam logic [15:0] PWR_M1   = 16'(POWER_SETTLE_CYC - 1);
   localparam logic [15:0] DEACT_M1 = 16'(DEACT_CYC - 1);
   localparam logic [15:0] RST_CNT  = 16'(RST_LOW);
   localparam logic [1:0]  CNT_LAST = 2'(CORR_MAX - 1);

   logic [1:0]  rsync;
   logic        rst_n;
   scn_state_t  st, next_st;
   logic [2:0]  cur, next_cur, nxt, next_nxt, supp, ind3, cand, up;
   logic [1:0]  cnt, next_cnt;
   logic        abt, next_abt, allow, up_ok, exp, corrupt_ev, no_atr;
   logic [15:0] tmr, tmo, ind_val, budget;
   logic [7:0]  div;
   logic        cclk, run, tick, ack, wr, vcc_r, rst_r, ind_v, session, gap;
   logic [2:0]  cls_r;
   logic [4:0]  ind5;
   logic [31:0] rdata;
   logic        start_p, abort_p, app_ver, app_cmd, app_status, app_ind;
   scn_atr_t    atr;

   function automatic logic [2:0] lowest(input logic [2:0] m);
      if (m[2]) return CLS_C;
      if (m[1]) return CLS_B;
      if (m[0]) return CLS_A;
      return 3'h0;
   endfunction : lowest

   function automatic logic [15:0] lim(input logic [2:0] c, input logic ses);
      unique case (c)
         CLS_A:   return ses ? SES_MA10_A : ATR_MA10_A;
         CLS_B:   return ses ? SES_MA10_B : ATR_MA10_B;
         CLS_C:   return ses ? SES_MA10_C : ATR_MA10_C;
         default: return 16'h0000;
      endcase
   endfunction : lim

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rsync <= 2'b00;
      end else begin
         rsync <= {rsync[0], 1'b1};
      end
   end
   assign rst_n = rsync[1];

   // Register port: one wait cycle, then the access completes
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;
   assign wr         = avs_write_in && ack;
   assign start_p    = wr && avs_address_in == OFS_CTRL && avs_writedata_in[CTRL_START];
   assign abort_p    = wr && avs_address_in == OFS_CTRL && avs_writedata_in[CTRL_ABORT];
   assign app_ver    = wr && avs_address_in == OFS_APP && avs_writedata_in[APP_VERIFIED];
   assign app_cmd    = wr && avs_address_in == OFS_APP && avs_writedata_in[APP_CMD];
   assign app_status = wr && avs_address_in == OFS_APP && avs_writedata_in[APP_STATUS];
   assign app_ind    = wr && avs_address_in == OFS_APP && avs_writedata_in[APP_IND_WR];

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read_in || avs_write_in) && !ack;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         allow <= 1'b0;
         supp  <= CTRL_SUPP_RST;
         tmo   <= ATR_TMO_RST;
      end else if (wr) begin
         if (avs_address_in == OFS_CTRL) begin
            allow <= avs_writedata_in[CTRL_ALLOW_UP];
            supp  <= avs_writedata_in[CTRL_SUPP_LSB +: 3];
         end
         if (avs_address_in == OFS_TMO) begin
            tmo <= avs_writedata_in[15:0];
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else if (avs_read_in && !ack) begin
         unique case (avs_address_in)
            OFS_CTRL:   rdata <= {25'h0, supp, 1'b0, allow, 2'h0};
            OFS_TMO:    rdata <= {16'h0, tmo};
            OFS_APP:    rdata <= {8'h0, ind_val, 4'h0, ind_v, 3'h0};
            OFS_STAT:   rdata <= {5'h0, gap, atr.t15, session, 2'h0, cnt, 3'h0, ind5,
                                  1'b0, cur, 1'b0, st};
            OFS_BUDGET: rdata <= {16'h0, budget};
            default:    rdata <= 32'h0000_0000;
         endcase
      end
   end
   assign avs_readdata_out = rdata;

   // Card clock divider, runs only while the contacts are live
   assign run  = st == S_CLKRST || st == S_WAIT || st == S_READY;
   assign tick = run && div == HALF_M1 && !cclk;

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         div  <= 8'h00;
         cclk <= 1'b0;
      end else if (!run) begin
         div  <= 8'h00;
         cclk <= 1'b0;
      end else if (div == HALF_M1) begin
         div  <= 8'h00;
         cclk <= !cclk;
      end else begin
         div <= div + 8'h01;
      end
   end

   // Characters before reset release are dropped, so only the answer is walked
   scn_atr_parse u_parse (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .clr_in   (st != S_WAIT),
      .chr_in   (atr_char_in),
      .atr_out  (atr)
   );

   // Missing indication is read as highest-voltage only
   assign ind3       = (atr.t15 && atr.cls_ok) ? atr.cls_ind[2:0] : CLS_A;
   assign cand       = ind3 & supp;
   assign up         = {1'b0, cur[2:1]};
   assign up_ok      = |(up & supp);
   assign exp        = st == S_WAIT && tmr == tmo;
   assign corrupt_ev = atr.corrupt || (exp && atr.seen);
   assign no_atr     = exp && !atr.seen;

   always_comb begin
      next_st  = st;
      next_cur = cur;
      next_nxt = nxt;
      next_cnt = cnt;
      next_abt = abt;
      unique case (st)
         S_IDLE, S_REJECT: begin
            if (start_p) begin
               next_abt = 1'b0;
               next_cnt = 2'h0;
               // Start carries the class set of its own write, not the stale one
               next_cur = lowest(avs_writedata_in[CTRL_SUPP_LSB +: 3]);
               next_st  = (|avs_writedata_in[CTRL_SUPP_LSB +: 3]) ? S_POWER : S_REJECT;
            end
         end
         S_POWER:  next_st = (tmr == PWR_M1) ? S_CLKRST : S_POWER;
         S_CLKRST: next_st = (tmr == RST_CNT) ? S_WAIT : S_CLKRST;
         S_WAIT: begin
            if (atr.done) begin
               next_cnt = 2'h0;
               if (|(ind3 & cur)) begin
                  next_st = S_READY;
               end else begin
                  next_nxt = lowest(cand);
                  next_st  = S_DEACT;
               end
            end else if (corrupt_ev) begin
               next_st = S_DEACT;
               if (cnt == CNT_LAST) begin
                  next_cnt = 2'h0;
                  next_nxt = (allow && up_ok) ? up : 3'h0;
               end else begin
                  next_cnt = cnt + 2'h1;
                  next_nxt = cur;
               end
            end else if (no_atr) begin
               next_cnt = 2'h0;
               next_nxt = up_ok ? up : 3'h0;
               next_st  = S_DEACT;
            end
         end
         S_READY: next_st = S_READY;
         S_DEACT: begin
            if (tmr == DEACT_M1) begin
               next_cur = nxt;
               next_st  = (|nxt) ? S_POWER : (abt ? S_IDLE : S_REJECT);
            end
         end
      endcase
      if (abort_p && st != S_IDLE && st != S_REJECT) begin
         next_abt = 1'b1;
         next_nxt = 3'h0;
         next_st  = S_DEACT;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st  <= S_IDLE;
         cur <= 3'h0;
         nxt <= 3'h0;
         cnt <= 2'h0;
         abt <= 1'b0;
      end else begin
         st  <= next_st;
         cur <= next_cur;
         nxt <= next_nxt;
         cnt <= next_cnt;
         abt <= next_abt;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tmr <= 16'h0000;
      end else if (next_st != st) begin
         tmr <= 16'h0000;
      end else if (st == S_POWER || st == S_DEACT || tick) begin
         tmr <= tmr + 16'h0001;
      end
   end

   // Contact pins follow the next state so they change with the state itself
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         vcc_r <= 1'b0;
         rst_r <= 1'b0;
         cls_r <= 3'h0;
      end else begin
         vcc_r <= next_st == S_POWER || next_st == S_CLKRST || next_st == S_WAIT ||
                  next_st == S_READY;
         rst_r <= next_st == S_WAIT || next_st == S_READY;
         cls_r <= (next_st == S_IDLE || next_st == S_REJECT || next_st == S_DEACT) ? 3'h0 : next_cur;
      end
   end
   assign card_out = '{vcc_en: vcc_r, cls: cls_r, rst_n: rst_r, clk: cclk};
   // Upper layers stay gated until class switching has settled
   assign card_ready_out = st == S_READY;
   assign reject_out     = st == S_REJECT;

   // Gap flag is kept for software; the choice still uses the low three bits
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ind5 <= 5'h00;
         gap  <= 1'b0;
      end else if (atr.done) begin
         ind5 <= atr.cls_ind;
         gap  <= |((atr.cls_ind + (atr.cls_ind & (~atr.cls_ind + 5'h01))) & atr.cls_ind);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         session <= 1'b0;
         ind_v   <= 1'b0;
         ind_val <= 16'h0000;
      end else if (st != S_READY) begin
         session <= 1'b0;
         ind_v   <= 1'b0;
      end else begin
         if (app_ver || app_cmd) begin
            session <= 1'b1;
         end
         if (app_ind) begin
            ind_v   <= 1'b1;
            ind_val <= avs_writedata_in[APP_IND_LSB +: 16];
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         budget <= 16'h0000;
      end else if (!session || st != S_READY) begin
         budget <= lim(cur, 1'b0);
      end else begin
         budget <= ind_v ? ind_val : lim(cur, 1'b1);
      end
   end
   assign budget_out = budget;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n);

   sequence s_start;
      (st == S_IDLE || st == S_REJECT) && start_p && (|avs_writedata_in[CTRL_SUPP_LSB +: 3]);
   endsequence
   sequence s_deact_entry;
      st != S_DEACT ##1 st == S_DEACT;
   endsequence
   sequence s_wait_ok;
      st == S_WAIT && !abort_p && atr.done;
   endsequence

   a_start_lowest: assert property (s_start |=> st == S_POWER && cur == lowest(supp))
      else $error("activation did not start at lowest class");
   a_no_answer_up: assert property (st == S_WAIT && !abort_p && !atr.done && !atr.corrupt && no_atr
      && up_ok |=> st == S_DEACT && nxt == $past(up))
      else $error("missing answer did not step up a class");
   a_deact_pins: assert property (s_deact_entry |-> !card_out.vcc_en && !card_out.rst_n)
      else $error("contacts live during deactivation");
   a_keep_class: assert property (s_wait_ok and (|(ind3 & cur)) |=> st == S_READY
      ##1 card_out.rst_n && card_out.vcc_en)
      else $error("supported class not kept");
   a_switch_indicated: assert property (s_wait_ok and (!(|(ind3 & cur)) && |cand)
      |=> st == S_DEACT && |(nxt & $past(ind3)) ##[1:260] st == S_POWER)
      else $error("class not switched to an indicated one");
   a_corrupt_same: assert property (st == S_WAIT && !abort_p && !atr.done && corrupt_ev
      && cnt != CNT_LAST |=> nxt == $past(cur) && cnt == $past(cnt) + 2'h1)
      else $error("corrupted answer not retried at same class");
   a_corrupt_next: assert property (st == S_WAIT && !abort_p && !atr.done && corrupt_ev
      && cnt == CNT_LAST |=> cnt == 2'h0 && nxt == ($past(allow && up_ok) ? $past(up) : 3'h0))
      else $error("wrong class after repeated corruption");
   a_no_ind_class_a: assert property (s_wait_ok and (!atr.cls_ok && cur == CLS_A) |=> st == S_READY)
      else $error("card without indication not run at highest class");
   a_status_only: assert property (st == S_READY && !session && app_status && !app_ver
      && !app_cmd && !abort_p |=> !session [*2])
      else $error("status query opened the session budget");
   a_atr_budget: assert property (st == S_READY && !session |=> budget_out == lim($past(cur), 1'b0))
      else $error("answer budget not applied");
   a_default_budget: assert property (st == S_READY && session && !ind_v
      |=> budget_out == lim($past(cur), 1'b1))
      else $error("default session budget not applied");
   a_ready_gate: assert property (card_ready_out |-> card_out.rst_n && card_out.vcc_en
      && card_out.cls == cur)
      else $error("ready before switching finished");
endmodule : scn_sequencer

// file: pkg/scn_pkg.sv
// Constants, field layouts and carrier types for the supply class sequencer.
// Assumes a 200 MHz system clock and a byte-addressed Avalon-MM register port.
package scn_pkg;
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned POWER_SETTLE_NS  = 1000;
   localparam int unsigned POWER_SETTLE_CYC = (POWER_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DEACT_NS         = 1000;
   localparam int unsigned DEACT_CYC        = (DEACT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CARD_HALF_CYC    = 25;
   localparam int unsigned RST_LOW_CLKS     = 400;
   localparam int unsigned CORRUPT_LIMIT    = 3;
   localparam logic [15:0] ATR_TMO_RST      = 16'h9c40;

   localparam logic [4:0]  OFS_CTRL   = 5'h00;
   localparam logic [4:0]  OFS_TMO    = 5'h04;
   localparam logic [4:0]  OFS_APP    = 5'h08;
   localparam logic [4:0]  OFS_STAT   = 5'h0c;
   localparam logic [4:0]  OFS_BUDGET = 5'h10;

   localparam int unsigned CTRL_START    = 0;
   localparam int unsigned CTRL_ABORT    = 1;
   localparam int unsigned CTRL_ALLOW_UP = 2;
   localparam int unsigned CTRL_SUPP_LSB = 4;
   localparam logic [2:0]  CTRL_SUPP_RST = 3'h7;
   localparam int unsigned APP_VERIFIED  = 0;
   localparam int unsigned APP_CMD       = 1;
   localparam int unsigned APP_STATUS    = 2;
   localparam int unsigned APP_IND_WR    = 3;
   localparam int unsigned APP_IND_LSB   = 8;

   localparam logic [2:0]  CLS_A = 3'h1;
   localparam logic [2:0]  CLS_B = 3'h2;
   localparam logic [2:0]  CLS_C = 3'h4;
   // Budgets in units of 0.1 mA
   localparam logic [15:0] ATR_MA10_A = 16'h0064;
   localparam logic [15:0] ATR_MA10_B = 16'h004b;
   localparam logic [15:0] ATR_MA10_C = 16'h0032;
   localparam logic [15:0] SES_MA10_A = 16'h0064;
   localparam logic [15:0] SES_MA10_B = 16'h004b;
   localparam logic [15:0] SES_MA10_C = 16'h0032;

   localparam logic [7:0]  TS_DIRECT  = 8'h3b;
   localparam logic [7:0]  TS_INVERSE = 8'h3f;
   localparam logic [3:0]  PROTO_GLOBAL = 4'hf;

   typedef enum logic [6:0] {
      S_IDLE   = 7'b0000001,
      S_POWER  = 7'b0000010,
      S_CLKRST = 7'b0000100,
      S_WAIT   = 7'b0001000,
      S_READY  = 7'b0010000,
      S_DEACT  = 7'b0100000,
      S_REJECT = 7'b1000000
   } scn_state_t;

   typedef enum logic [5:0] {
      P_TS   = 6'b000001,
      P_T0   = 6'b000010,
      P_IF   = 6'b000100,
      P_HIST = 6'b001000,
      P_TCK  = 6'b010000,
      P_END  = 6'b100000
   } scn_pstate_t;

   typedef struct packed {
      logic       vcc_en;
      logic [2:0] cls;
      logic       rst_n;
      logic       clk;
   } scn_card_t;

   typedef struct packed {
      logic       valid;
      logic       err;
      logic [7:0] data;
   } scn_char_t;

   typedef struct packed {
      logic       done;
      logic       corrupt;
      logic       seen;
      logic       t15;
      logic       cls_ok;
      logic [4:0] cls_ind;
   } scn_atr_t;
endpackage : scn_pkg

// file: core/scn_atr_parse.sv
// Answer-to-reset structure walker: follows the interface byte chain and checksum.
// Assumes an outside receiver delivers one decoded character per valid pulse.
`timescale 1ns/1ps
module scn_atr_parse (
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                clr_in,
   input  wire scn_pkg::scn_char_t  chr_in,
   output scn_pkg::scn_atr_t        atr_out
);
   import scn_pkg::*;

   scn_pstate_t pst, n_pst;
   logic [3:0]  pend, n_pend, lb, hist, grp, curt;
   logic        need_tck, n_tck, bad;
   logic [7:0]  xsum;

   function automatic scn_pstate_t after(input logic [3:0] p, input logic [3:0] h, input logic t);
      if (p != 4'h0) return P_IF;
      if (h != 4'h0) return P_HIST;
      if (t) return P_TCK;
      return P_END;
   endfunction : after

   always_comb begin
      lb     = pend & (~pend + 4'h1);
      n_pend = pend & ~lb;
      n_tck  = need_tck;
      n_pst  = pst;
      bad    = chr_in.err;
      unique case (pst)
         P_TS: begin
            bad   = chr_in.err || (chr_in.data != TS_DIRECT && chr_in.data != TS_INVERSE);
            n_pst = P_T0;
         end
         P_T0: begin
            n_pend = chr_in.data[7:4];
            n_pst  = after(chr_in.data[7:4], chr_in.data[3:0], 1'b0);
         end
         P_IF: begin
            if (lb[3]) begin
               n_pend = chr_in.data[7:4];
               n_tck  = need_tck || (chr_in.data[3:0] != 4'h0);
            end
            n_pst = after(n_pend, hist, n_tck);
         end
         P_HIST: n_pst = (hist == 4'h1) ? (need_tck ? P_TCK : P_END) : P_HIST;
         P_TCK: begin
            bad   = chr_in.err || ((xsum ^ chr_in.data) != 8'h00);
            n_pst = P_END;
         end
         P_END: n_pst = P_END;
      endcase
      if (bad) begin
         n_pst = P_END;
      end
   end

   // Other protocols and history bytes are walked, never refused; a bad check byte flags corrupt
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pst      <= P_TS;
         pend     <= 4'h0;
         hist     <= 4'h0;
         grp      <= 4'h0;
         curt     <= 4'h0;
         need_tck <= 1'b0;
         xsum     <= 8'h00;
         atr_out  <= '0;
      end else if (clr_in) begin
         pst      <= P_TS;
         pend     <= 4'h0;
         need_tck <= 1'b0;
         xsum     <= 8'h00;
         atr_out  <= '0;
      end else begin
         atr_out.done    <= 1'b0;
         atr_out.corrupt <= 1'b0;
         if (chr_in.valid && pst != P_END) begin
            atr_out.seen    <= 1'b1;
            atr_out.corrupt <= bad;
            atr_out.done    <= !bad && n_pst == P_END;
            pst             <= n_pst;
            pend            <= n_pend;
            need_tck        <= n_tck;
            if (pst != P_TS) begin
               xsum <= xsum ^ chr_in.data;
            end
            if (pst == P_T0) begin
               hist <= chr_in.data[3:0];
               grp  <= 4'h1;
               curt <= 4'h0;
            end
            if (pst == P_HIST) begin
               hist <= hist - 4'h1;
            end
            // Class byte is a global byte of group three or later
            if (pst == P_IF && lb[0] && grp > 4'h2 && curt == PROTO_GLOBAL) begin
               atr_out.cls_ok  <= 1'b1;
               atr_out.cls_ind <= chr_in.data[4:0];
            end
            if (pst == P_IF && lb[3]) begin
               curt <= chr_in.data[3:0];
               grp  <= grp + 4'h1;
               if (chr_in.data[3:0] == PROTO_GLOBAL) begin
                  atr_out.t15 <= 1'b1;
               end
            end
         end
      end
   end
endmodule : scn_atr_parse

// file: testbench/scn_card_model.sv
// Behavioural card: answers every reset release with a scripted answer, except in mode 1 where it stays silent.
// Assumes the contacts are sampled on the sequencer's own clock.
`timescale 1ns/1ps
module scn_card_model (
   input  wire logic                clk_in,
   input  wire scn_pkg::scn_card_t  card_in,
   input  wire logic [1:0]          mode_in,
   input  wire logic [7:0]          cls_in,
   output scn_pkg::scn_char_t       chr_out
);
   import scn_pkg::*;
   logic       v = 1'b0;
   logic       e = 1'b0;
   logic       f = 1'b0;
   logic [7:0] d = 8'h00;
   logic [7:0] b [6];
   // Idle data toggles, so a stale byte never looks like a character
   always @(posedge clk_in) f <= ~f;
   assign chr_out = '{valid: v, err: e, data: v ? d : d ^ {8{f}}};
   initial forever begin
      @(posedge card_in.rst_n);
      b = '{TS_DIRECT, 8'h80, 8'h80, {4'h1, PROTO_GLOBAL}, cls_in, 8'h1f ^ cls_in};
      if (mode_in == 2'h3) b[1] = 8'h00;
      for (int i = 0; i < (mode_in == 2'h3 ? 2 : 6) && mode_in != 2'h1; i++) begin
         repeat (4) @(posedge clk_in);
         if (!card_in.rst_n) break;
         d <= b[i];
         v <= 1'b1;
         e <= (mode_in == 2'h2 && i == 2);
         @(posedge clk_in);
         v <= 1'b0;
      end
   end
endmodule : scn_card_model

// file: testbench/testbench.sv
// Self-checking bench for the supply class sequencer.
// Assumes the card model above stands on the character and contact pins.
`timescale 1ns/1ps
module testbench;
   import scn_pkg::*;
   logic        ref_clk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata, q;
   logic        wreq, ready, rej, pv;
   logic [15:0] budget, ind;
   scn_char_t   chr;
   scn_card_t   card;
   logic [1:0]  mode = 2'h0;
   logic [7:0]  cls = 8'h00;
   logic [23:0] seq;
   int          num_errors = 0;
   int          checks_done = 0;
   int          cyc = 0;
   always #2.5 ref_clk_in = ~ref_clk_in;
   scn_sequencer #(.CARD_HALF(2), .RST_LOW(4)) u_scn_sequencer (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .atr_char_in(chr), .card_out(card),
      .card_ready_out(ready), .reject_out(rej), .budget_out(budget));
   scn_card_model u_scn_card_model (.clk_in(ref_clk_in), .card_in(card), .mode_in(mode), .cls_in(cls),
      .chr_out(chr));
   // Log of the class applied at each power-up, three bits per step
   always @(posedge ref_clk_in) begin
      cyc++;
      pv <= card.vcc_en;
      if (card.vcc_en && !pv) seq <= {seq[20:0], card.cls};
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task report_and_stop;
      if (num_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task bus(input logic w, input logic [4:0] a, input logic [31:0] dt);
      @(posedge ref_clk_in);
      adr <= a;
      rd <= !w;
      wr <= w;
      wd <= dt;
      do @(posedge ref_clk_in); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task run(input logic [2:0] supp, input logic up, input logic [1:0] m, input logic [7:0] c);
      mode <= m;
      cls <= c;
      seq <= '0;
      bus(1'b1, OFS_CTRL, {25'h0, supp, 1'b0, up, 2'h1});
      // State moves at the ack edge; polling there would see the old reject level
      @(posedge ref_clk_in);
      for (int i = 0; i < 9000 && !ready && !rej; i++) @(posedge ref_clk_in);
   endtask : run
   initial begin
      void'($urandom(19));
      repeat (8) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl reset", 32'h70, q);
      bus(1'b0, OFS_TMO, 32'h0);
      chk("tmo reset", {16'h0, ATR_TMO_RST}, q);
      bus(1'b1, OFS_TMO, 32'h14);
      // Card offers B only: start at C, then move to B
      run(3'h7, 1'b0, 2'h0, 8'h02);
      chk("classes", 24'h000022, seq);
      chk("ready", 32'h1, ready);
      chk("budget", ATR_MA10_B, budget);
      ind = 16'($urandom_range(1, 499));
      bus(1'b1, OFS_APP, 32'h4);
      bus(1'b1, OFS_APP, {8'h0, ind, 8'h08});
      repeat (2) @(posedge ref_clk_in);
      chk("budget", ATR_MA10_B, budget);
      bus(1'b1, OFS_APP, 32'h2);
      repeat (2) @(posedge ref_clk_in);
      chk("budget", ind, budget);
      bus(1'b0, 5'h14, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b1, OFS_CTRL, 32'h72);
      repeat (210) @(posedge ref_clk_in);
      // Silent card: B, then A, then give up
      run(3'h3, 1'b0, 2'h1, 8'h00);
      chk("classes", 24'h000011, seq);
      chk("reject", 32'h1, rej);
      run(3'h7, 1'b0, 2'h2, 8'h06);
      chk("classes", 24'h000124, seq);
      run(3'h6, 1'b1, 2'h2, 8'h06);
      chk("classes", 24'h024892, seq);
      // No class byte: highest-voltage class only
      run(3'h7, 1'b0, 2'h3, 8'h00);
      chk("classes", 24'h000021, seq);
      chk("budget", ATR_MA10_A, budget);
      bus(1'b1, OFS_APP, 32'h1);
      repeat (2) @(posedge ref_clk_in);
      chk("budget", SES_MA10_A, budget);
      bus(1'b0, OFS_BUDGET, 32'h0);
      chk("budget reg", {16'h0, SES_MA10_A}, q);
      bus(1'b0, OFS_STAT, 32'h0);
      chk("status", 32'h0100_0110, q);
      report_and_stop();
   end
endmodule : testbench
